// file: fault_supervisor.sv
// Fault, restart and setpoint supervisor with AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module fault_supervisor #(
    parameter int unsigned GRACE_CYC =
        supervisor_pkg::GRACE_S * supervisor_pkg::CLK_HZ,
    parameter int unsigned DELAY_CYC =
        supervisor_pkg::RESTART_DELAY_S * supervisor_pkg::CLK_HZ,
    parameter int unsigned WINDOW_CYC =
        supervisor_pkg::OV_WINDOW_S * supervisor_pkg::CLK_HZ,
    parameter int unsigned MIN_OFF_CYC =
        supervisor_pkg::MIN_OFF_S * supervisor_pkg::CLK_HZ,
    parameter int unsigned BLINK_CYC = supervisor_pkg::CLK_HZ / 4,
    parameter int SETPT_W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Power stage status
    input wire logic remote_on,
    input wire logic present,
    input wire logic limit_active,
    input wire logic vout_above_10v,
    input wire logic oc_fault,
    input wire logic ot_fault,
    input wire logic ov_fault,
    input wire logic [SETPT_W-1:0] prog_pin_setpt,
    // Power stage control
    output logic main_on,
    output logic [SETPT_W-1:0] setpt,
    output logic out_led,
    output logic alert_n,
    output logic irq,
    // AXI4-Lite write
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    supervisor_pkg::state_type st_q, st_d;
    logic [31:0] tmr_q, tmr_d, win_q, win_d, grace_q, grace_d;
    logic [1:0] ovcnt_q, ovcnt_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic sw_setpt_q, sw_setpt_d, restarted_q, restarted_d;
    logic [SETPT_W-1:0] setpt_q, setpt_d, swval_q, swval_d;
    logic [3:0] stat_q, stat_d, mask_q, mask_d;
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic led_q, led_d, on_q, on_d, irq_q, irq_d, alert_n_q, alert_n_d;
    logic [31:0] blink_q, blink_d;
    logic octl_q, otl_q, awr_q, wr_q, arr_q;
    logic do_wr, rd_take, ev_state, ev_latch, ev_rst, ev_err, want_on;

    // Decodes an offset into a mapped-register flag
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == supervisor_pkg::CTRL_OFFS) ||
            (a == supervisor_pkg::STATE_OFFS) ||
            (a == supervisor_pkg::IRQ_STAT_OFFS) ||
            (a == supervisor_pkg::IRQ_MASK_OFFS) ||
            (a == supervisor_pkg::SETPT_OFFS) ||
            (a == supervisor_pkg::STATUS2_OFFS);
    endfunction

    // Bus slave handshakes and register writes
    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rr_d = rr_q;
        rd_d = rd_q;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        sw_setpt_d = sw_setpt_q;
        swval_d = swval_q;
        do_wr = 1'b0;
        rd_take = 1'b0;
        if (s_awvalid && !aw_q && !bv_q) begin
            aw_d = 1'b1;
            awa_d = s_awaddr;
        end
        if (s_wvalid && !w_q && !bv_q) begin
            w_d = 1'b1;
            wd_d = s_wdata;
        end
        if (aw_q && w_q) begin
            do_wr = 1'b1;
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = mapped(awa_q) ? supervisor_pkg::RESP_OKAY
                : supervisor_pkg::RESP_SLVERR;
            if (awa_q == supervisor_pkg::CTRL_OFFS) begin
                ctrl_d = wd_q[2:0];
            end
            if (awa_q == supervisor_pkg::IRQ_MASK_OFFS) begin
                mask_d = wd_q[3:0];
            end
            if (awa_q == supervisor_pkg::SETPT_OFFS) begin
                sw_setpt_d = 1'b1;
                swval_d = wd_q[SETPT_W-1:0];
            end
        end
        if (bv_q && s_bready) begin
            bv_d = 1'b0;
        end
        if (s_arvalid && !rv_q) begin
            rd_take = 1'b1;
            rv_d = 1'b1;
            rr_d = mapped(s_araddr) ? supervisor_pkg::RESP_OKAY
                : supervisor_pkg::RESP_SLVERR;
            case (s_araddr)
                supervisor_pkg::CTRL_OFFS: rd_d = {29'h0, ctrl_q};
                supervisor_pkg::STATE_OFFS: rd_d = {24'h0, ovcnt_q, st_q};
                supervisor_pkg::IRQ_STAT_OFFS: rd_d = {28'h0, stat_q};
                supervisor_pkg::IRQ_MASK_OFFS: rd_d = {28'h0, mask_q};
                supervisor_pkg::SETPT_OFFS: rd_d = 32'(setpt_q);
                supervisor_pkg::STATUS2_OFFS: rd_d = {31'h0, restarted_q};
                default: rd_d = 32'h0;
            endcase
        end else if (rv_q && s_rready) begin
            rv_d = 1'b0;
        end
    end

    // Setpoint source follows pin until the bus claims it
    always_comb begin
        setpt_d = sw_setpt_q ? swval_q : prog_pin_setpt;
    end

    // Supervisor state machine and timers
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q;
        win_d = win_q;
        ovcnt_d = ovcnt_q;
        grace_d = grace_q;
        restarted_d = restarted_q;
        ev_latch = 1'b0;
        ev_rst = 1'b0;
        want_on = remote_on && ctrl_q[supervisor_pkg::CTRL_ON_BIT] &&
            present;
        // OV window clears the trip count when it expires
        if (win_q != 32'h0) begin
            win_d = win_q - 32'h1;
            if (win_q == 32'h1) begin
                ovcnt_d = 2'h0;
            end
        end
        if (tmr_q != 32'h0) begin
            tmr_d = tmr_q - 32'h1;
        end
        case (st_q)
            supervisor_pkg::ST_OFF: begin
                if (want_on && tmr_q == 32'h0) begin
                    st_d = supervisor_pkg::ST_ON;
                    grace_d = GRACE_CYC;
                end
            end
            supervisor_pkg::ST_ON, supervisor_pkg::ST_LIMIT: begin
                if (grace_q != 32'h0) begin
                    grace_d = grace_q - 32'h1;
                end
                if (!want_on) begin
                    st_d = supervisor_pkg::ST_OFF;
                    tmr_d = MIN_OFF_CYC;
                end else if (ov_fault) begin
                    ovcnt_d = ovcnt_q + 2'h1;
                    if (ovcnt_q == 2'h0) begin
                        win_d = WINDOW_CYC;
                    end
                    if (ovcnt_q + 2'h1 >= 2'(supervisor_pkg::OV_MAX_TRIES))
                    begin
                        st_d = supervisor_pkg::ST_LATCHED;
                    end else begin
                        st_d = supervisor_pkg::ST_RETRY;
                        tmr_d = DELAY_CYC;
                    end
                end else if ((oc_fault && ctrl_q[1]) || (ot_fault && ctrl_q[2]))
                begin
                    st_d = supervisor_pkg::ST_LATCHED;
                end else if (oc_fault || ot_fault) begin
                    st_d = supervisor_pkg::ST_RETRY;
                    tmr_d = DELAY_CYC;
                end else if (limit_active) begin
                    if (grace_q != 32'h0) begin
                        st_d = supervisor_pkg::ST_LIMIT;
                    end else if (!vout_above_10v) begin
                        st_d = supervisor_pkg::ST_HICCUP;
                        tmr_d = DELAY_CYC;
                    end else begin
                        st_d = supervisor_pkg::ST_LIMIT;
                    end
                end else begin
                    st_d = supervisor_pkg::ST_ON;
                end
            end
            supervisor_pkg::ST_HICCUP, supervisor_pkg::ST_RETRY: begin
                if (!want_on) begin
                    st_d = supervisor_pkg::ST_OFF;
                    tmr_d = MIN_OFF_CYC;
                end else if (tmr_q == 32'h0) begin
                    st_d = supervisor_pkg::ST_ON;
                    grace_d = 32'h0;
                end
            end
            supervisor_pkg::ST_LATCHED: begin
                // Off cycles or reconfiguration release the latch
                if (!want_on) begin
                    st_d = supervisor_pkg::ST_OFF;
                    tmr_d = MIN_OFF_CYC;
                    ovcnt_d = 2'h0;
                    ev_rst = 1'b1;
                end else if ((octl_q && !ctrl_q[1]) ||
                    (otl_q && !ctrl_q[2])) begin
                    st_d = supervisor_pkg::ST_ON;
                    ovcnt_d = 2'h0;
                    ev_rst = 1'b1;
                end
            end
            default: st_d = supervisor_pkg::ST_OFF;
        endcase
        if (ev_rst) begin
            restarted_d = 1'b1;
        end
        if (st_d == supervisor_pkg::ST_LATCHED &&
            st_q != supervisor_pkg::ST_LATCHED) begin
            ev_latch = 1'b1;
        end
    end

    // Indicator, output enable, sticky alarms and alert
    always_comb begin
        ev_state = st_d != st_q;
        ev_err = (do_wr && !mapped(awa_q)) ||
            (rd_take && !mapped(s_araddr));
        blink_d = (blink_q == 32'h0) ? BLINK_CYC : blink_q - 32'h1;
        case (st_q)
            supervisor_pkg::ST_ON: led_d = 1'b1;
            supervisor_pkg::ST_LIMIT: begin
                led_d = vout_above_10v ? (blink_q == 32'h0 ? !led_q : led_q)
                    : 1'b1;
            end
            default: led_d = 1'b0;
        endcase
        on_d = st_d == supervisor_pkg::ST_ON ||
            st_d == supervisor_pkg::ST_LIMIT;
        stat_d = stat_q;
        if (rd_take && s_araddr == supervisor_pkg::IRQ_STAT_OFFS) begin
            stat_d = 4'h0;
        end
        if (ev_rst) begin
            stat_d = 4'h0;
        end
        // Sets win over the read clear
        stat_d[supervisor_pkg::IRQ_STATE_BIT] =
            stat_d[supervisor_pkg::IRQ_STATE_BIT] | ev_state;
        stat_d[supervisor_pkg::IRQ_LATCH_BIT] =
            stat_d[supervisor_pkg::IRQ_LATCH_BIT] | ev_latch;
        stat_d[supervisor_pkg::IRQ_RESTART_BIT] =
            stat_d[supervisor_pkg::IRQ_RESTART_BIT] | ev_rst;
        stat_d[supervisor_pkg::IRQ_BUSERR_BIT] =
            stat_d[supervisor_pkg::IRQ_BUSERR_BIT] | ev_err;
        irq_d = |(stat_d & mask_q);
        // Alert ignores the mask and clears with the status read
        alert_n_d = !(|stat_d);
    end

    // Registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= supervisor_pkg::ST_OFF;
            {tmr_q, win_q, grace_q, blink_q} <= '0;
            ovcnt_q <= 2'h0;
            ctrl_q <= supervisor_pkg::CTRL_RESET;
            mask_q <= supervisor_pkg::MASK_RESET;
            stat_q <= 4'h0;
            {sw_setpt_q, restarted_q, led_q, on_q, irq_q} <= '0;
            {aw_q, w_q, bv_q, rv_q} <= '0;
            {setpt_q, swval_q, awa_q, wd_q, rd_q} <= '0;
            {br_q, rr_q} <= '0;
            {octl_q, otl_q} <= 2'h0;
            alert_n_q <= 1'b1;
            {awr_q, wr_q, arr_q} <= 3'h7;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            win_q <= win_d;
            grace_q <= grace_d;
            blink_q <= blink_d;
            ovcnt_q <= ovcnt_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            sw_setpt_q <= sw_setpt_d;
            restarted_q <= restarted_d;
            led_q <= led_d;
            on_q <= on_d;
            irq_q <= irq_d;
            {aw_q, w_q, bv_q, rv_q} <= {aw_d, w_d, bv_d, rv_d};
            {setpt_q, swval_q, awa_q, wd_q, rd_q} <=
                {setpt_d, swval_d, awa_d, wd_d, rd_d};
            {br_q, rr_q} <= {br_d, rr_d};
            {octl_q, otl_q} <= {ctrl_q[1], ctrl_q[2]};
            alert_n_q <= alert_n_d;
            {awr_q, wr_q, arr_q} <= {!aw_d && !bv_d, !w_d && !bv_d, !rv_d};
        end
    end

    // Outputs from flip-flops
    assign main_on = on_q;
    assign setpt = setpt_q;
    assign out_led = led_q;
    assign alert_n = alert_n_q;
    assign irq = irq_q;
    assign s_awready = awr_q;
    assign s_wready = wr_q;
    assign s_bvalid = bv_q;
    assign s_bresp = br_q;
    assign s_arready = arr_q;
    assign s_rvalid = rv_q;
    assign s_rdata = rd_q;
    assign s_rresp = rr_q;

    // Checks
    latch_holds_a: assert property (@(posedge core_clk) disable iff (reset)
        st_q == supervisor_pkg::ST_LATCHED && want_on &&
        !((octl_q && !ctrl_q[1]) || (otl_q && !ctrl_q[2]))
        |=> st_q == supervisor_pkg::ST_LATCHED)
        else $error("latch released without mechanism");
    off_output_a: assert property (@(posedge core_clk) disable iff (reset)
        !want_on |=> !main_on)
        else $error("output stayed on after off request");
    led_off_a: assert property (@(posedge core_clk) disable iff (reset)
        st_q == supervisor_pkg::ST_LATCHED |=> !out_led)
        else $error("indicator lit while latched");
    setpt_sw_a: assert property (@(posedge core_clk) disable iff (reset)
        sw_setpt_q |=> setpt == $past(swval_q))
        else $error("setpoint followed pin after bus command");
    restart_flag_a: assert property (@(posedge core_clk) disable iff (reset)
        ev_rst |=> restarted_q && stat_q[2])
        else $error("restart flag not set");
    alert_a: assert property (@(posedge core_clk) disable iff (reset)
        ev_state |=> !alert_n)
        else $error("alert not raised on state change");
    min_off_a: assert property (@(posedge core_clk) disable iff (reset)
        (st_q == supervisor_pkg::ST_LATCHED &&
        st_d == supervisor_pkg::ST_OFF) |=> tmr_q == MIN_OFF_CYC)
        else $error("minimum off time not loaded");
    hiccup_a: assert property (@(posedge core_clk) disable iff (reset)
        (st_q == supervisor_pkg::ST_ON || st_q == supervisor_pkg::ST_LIMIT)
        && want_on && !ov_fault && !oc_fault
        && !ot_fault && limit_active && grace_q == 32'h0 && !vout_above_10v
        |=> st_q == supervisor_pkg::ST_HICCUP)
        else $error("no hiccup on low-voltage limit");
    latch_c: cover property (@(posedge core_clk) ev_latch);
    restart_c: cover property (@(posedge core_clk) ev_rst);
    hiccup_c: cover property (@(posedge core_clk)
        st_q == supervisor_pkg::ST_HICCUP);
endmodule

// file: supervisor_pkg.sv
// Constants shared by the power supply fault and restart supervisor
package supervisor_pkg;
    // Clock rate and derived second counts
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned GRACE_S = 20;
    localparam int unsigned RESTART_DELAY_S = 1;
    localparam int unsigned OV_WINDOW_S = 60;
    localparam int unsigned MIN_OFF_S = 2;
    localparam int unsigned OV_MAX_TRIES = 3;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFS = 8'h00;
    localparam logic [7:0] STATE_OFFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFFS = 8'h0C;
    localparam logic [7:0] SETPT_OFFS = 8'h10;
    localparam logic [7:0] STATUS2_OFFS = 8'h14;
    // Control register bit positions
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_OC_LATCH_BIT = 1;
    localparam int CTRL_OT_LATCH_BIT = 2;
    // Interrupt status bit positions
    localparam int IRQ_STATE_BIT = 0;
    localparam int IRQ_LATCH_BIT = 1;
    localparam int IRQ_RESTART_BIT = 2;
    localparam int IRQ_BUSERR_BIT = 3;
    // Reset values
    localparam logic [2:0] CTRL_RESET = 3'h1;
    localparam logic [3:0] MASK_RESET = 4'h0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Supervisor states
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_ON = 6'h02,
        ST_LIMIT = 6'h04,
        ST_HICCUP = 6'h08,
        ST_RETRY = 6'h10,
        ST_LATCHED = 6'h20
    } state_type;
endpackage

// file: host_model.sv
// Host model driving the remote on/off and presence pins
`timescale 1ns/100ps
module host_model #(
    parameter int unsigned OFF_CYC = 20
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Requests from the bench
    input wire logic hold_off,
    input wire logic cycle_remote,
    input wire logic cycle_present,
    // Pins to the supply
    output logic remote_on,
    output logic present,
    output logic busy
);
    int unsigned cnt_q;
    logic pres_q;
    // Off phase of a cycle lasts OFF_CYC + 4 cycles, 4 more than the minimum off time when OFF_CYC is set to it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_q <= 0;
            pres_q <= 1'b0;
        end else if (cycle_remote || cycle_present) begin
            cnt_q <= OFF_CYC + 4;
            pres_q <= cycle_present;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    // Pin goes off then on again to release a latched unit
    assign remote_on = !hold_off && (cnt_q == 0 || pres_q);
    assign present = cnt_q == 0 || !pres_q;
    assign busy = cnt_q != 0;
endmodule

// file: tb_top.sv
// Self-checking testbench for the fault and restart supervisor
`timescale 1ns/100ps
module tb_top;
    localparam int unsigned GRACE = 40;
    localparam int unsigned DELAY = 10;
    localparam int unsigned WINDOW = 200;
    localparam int unsigned MINOFF = 20;
    localparam int unsigned BLINK = 8;
    // Supply pins and host requests
    logic core_clk, reset, remote_on, present, limit_active, vout_above_10v;
    logic oc_fault, ot_fault, ov_fault, hold_off, cycle_remote, cycle_present;
    logic [7:0] prog_pin_setpt, setpt, s_awaddr, s_araddr;
    logic main_on, out_led, alert_n, irq, busy;
    // Register bus
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, rr;
    int mismatches, n_compared, cycles;

    fault_supervisor #(.GRACE_CYC(GRACE), .DELAY_CYC(DELAY), .BLINK_CYC(BLINK),
        .WINDOW_CYC(WINDOW), .MIN_OFF_CYC(MINOFF), .SETPT_W(8)) dut (
        .core_clk(core_clk), .reset(reset), .remote_on(remote_on),
        .present(present), .limit_active(limit_active),
        .vout_above_10v(vout_above_10v), .oc_fault(oc_fault),
        .ot_fault(ot_fault), .ov_fault(ov_fault),
        .prog_pin_setpt(prog_pin_setpt), .main_on(main_on), .setpt(setpt),
        .out_led(out_led), .alert_n(alert_n), .irq(irq),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready));
    host_model #(.OFF_CYC(MINOFF)) host (.core_clk(core_clk), .reset(reset),
        .hold_off(hold_off), .cycle_remote(cycle_remote),
        .cycle_present(cycle_present), .remote_on(remote_on),
        .present(present), .busy(busy));

    // Clock generator
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Watchdog cuts a hang short
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end
    // Counts and verdict
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Compare one value
    task automatic check_value(input logic [31:0] got, input logic [31:0] exp,
        input string msg);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got,
                exp);
        end
    endtask
    // Bus write, each channel released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        check_value(s_bresp, supervisor_pkg::RESP_OKAY, "write response");
        s_bready <= 1'b0;
        @(posedge core_clk);
    endtask
    // Bus read
    task automatic axi_read(input logic [7:0] a);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        rd = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
        @(posedge core_clk);
    endtask
    // Wait bounded for the main output level
    task automatic wait_main(input logic exp);
        int n;
        n = 0;
        while (main_on !== exp && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        check_value(main_on, exp, "main output");
    endtask
    // One cycle fault pulse: 0 over voltage, 1 over current, 2 over temp
    task automatic fault_pulse(input int k);
        ov_fault <= k == 0;
        oc_fault <= k == 1;
        ot_fault <= k == 2;
        @(posedge core_clk);
        {ov_fault, oc_fault, ot_fault} <= 3'h0;
        @(posedge core_clk);
    endtask
    // Reset values, unmapped access and alert
    task automatic test_regs();
        axi_read(supervisor_pkg::CTRL_OFFS);
        check_value(rd, 32'h1, "control reset");
        axi_read(supervisor_pkg::IRQ_MASK_OFFS);
        check_value(rd, 32'h0, "mask reset");
        axi_read(supervisor_pkg::IRQ_STAT_OFFS);
        axi_read(8'h40);
        check_value(rr, supervisor_pkg::RESP_SLVERR, "unmapped resp");
        check_value(alert_n, 1'b0, "alert after error");
        axi_read(supervisor_pkg::IRQ_STAT_OFFS);
        check_value(rd[3], 1'b1, "bus error flag");
        $display("test regs done");
    endtask
    // Pin sets the setpoint until the bus writes it
    task automatic test_setpt();
        prog_pin_setpt <= 8'h3C;
        repeat (3) @(posedge core_clk);
        check_value(setpt, 8'h3C, "pin setpoint");
        axi_write(supervisor_pkg::SETPT_OFFS, 32'hA7);
        prog_pin_setpt <= 8'h11;
        repeat (3) @(posedge core_clk);
        check_value(setpt, 8'hA7, "bus setpoint");
        $display("test setpt done");
    endtask
    // Remote off and on, with indicator and masked interrupt
    task automatic test_onoff();
        wait_main(1'b1);
        @(posedge core_clk);
        check_value(out_led, 1'b1, "led on");
        axi_read(supervisor_pkg::IRQ_STAT_OFFS);
        axi_write(supervisor_pkg::IRQ_MASK_OFFS, 32'h0);
        hold_off <= 1'b1;
        wait_main(1'b0);
        repeat (2) @(posedge core_clk);
        check_value(out_led, 1'b0, "led off");
        check_value(irq, 1'b0, "irq masked");
        check_value(alert_n, 1'b0, "alert on state change");
        axi_write(supervisor_pkg::IRQ_MASK_OFFS, 32'hF);
        check_value(irq, 1'b1, "irq unmasked");
        axi_read(supervisor_pkg::IRQ_STAT_OFFS);
        check_value(rd[0], 1'b1, "state change flag");
        @(posedge core_clk);
        check_value(irq, 1'b0, "irq cleared");
        hold_off <= 1'b0;
        wait_main(1'b1);
        $display("test onoff done");
    endtask
    // Two over voltage trips, window expires, two more: no latch
    task automatic test_ov_window();
        for (int i = 0; i < 4; i++) begin
            if (i == 2) repeat (WINDOW + 20) @(posedge core_clk);
            fault_pulse(0);
            wait_main(1'b0);
            repeat (DELAY - 3) @(posedge core_clk);
            check_value(main_on, 1'b0, "retry delay");
            wait_main(1'b1);
        end
        repeat (WINDOW + 20) @(posedge core_clk);
        $display("test ov window done");
    endtask
    // Latch by each fault kind, release by each mechanism
    task automatic test_latch();
        for (int m = 0; m < 4; m++) begin
            axi_write(supervisor_pkg::CTRL_OFFS, m == 2 ? 32'h5 :
                (m == 0 ? 32'h1 : 32'h3));
            wait_main(1'b1);
            if (m == 0) begin
                for (int i = 0; i < 3; i++) begin
                    fault_pulse(0);
                    if (i < 2) wait_main(1'b1);
                end
            end else begin
                fault_pulse(m == 2 ? 2 : 1);
            end
            wait_main(1'b0);
            repeat (MINOFF * 3) @(posedge core_clk);
            check_value(main_on, 1'b0, "stays latched");
            axi_read(supervisor_pkg::STATE_OFFS);
            check_value(rd[5:0], 6'h20, "latched state");
            check_value(out_led, 1'b0, "led latched");
            case (m)
                0: cycle_remote <= 1'b1;
                2: cycle_present <= 1'b1;
                1: axi_write(supervisor_pkg::CTRL_OFFS, 32'h2);
                default: axi_write(supervisor_pkg::CTRL_OFFS, 32'h1);
            endcase
            @(posedge core_clk);
            {cycle_remote, cycle_present} <= 2'h0;
            if (m == 0 || m == 2) begin
                repeat (MINOFF) @(posedge core_clk);
                check_value({busy, main_on}, 2'h2, "held off");
            end
            if (m == 1) begin
                repeat (MINOFF + 4) @(posedge core_clk);
                axi_write(supervisor_pkg::CTRL_OFFS, 32'h3);
            end
            wait_main(1'b1);
            axi_read(supervisor_pkg::STATUS2_OFFS);
            check_value(rd[0], 1'b1, "restart flag");
            axi_read(supervisor_pkg::IRQ_STAT_OFFS);
            check_value(rd[2:1], 2'h2, "alarms on restart");
        end
        fault_pulse(1);
        wait_main(1'b0);
        wait_main(1'b1);
        $display("test latch done");
    endtask
    // Limit in grace, hiccup below 10 V, limit above 10 V
    task automatic test_limit();
        logic led0;
        hold_off <= 1'b1;
        wait_main(1'b0);
        limit_active <= 1'b1;
        vout_above_10v <= 1'b0;
        hold_off <= 1'b0;
        wait_main(1'b1);
        axi_read(supervisor_pkg::STATE_OFFS);
        check_value(rd[5:0], 6'h04, "grace limit");
        repeat (GRACE + 5) @(posedge core_clk);
        axi_read(supervisor_pkg::STATE_OFFS);
        check_value(rd[5:0], 6'h08, "hiccup");
        limit_active <= 1'b0;
        wait_main(1'b1);
        repeat (GRACE + 5) @(posedge core_clk);
        limit_active <= 1'b1;
        vout_above_10v <= 1'b1;
        repeat (3) @(posedge core_clk);
        axi_read(supervisor_pkg::STATE_OFFS);
        check_value(rd[5:0], 6'h04, "limit above 10 V");
        check_value(main_on, 1'b1, "on in limit");
        led0 = out_led;
        repeat (BLINK + 1) @(posedge core_clk);
        check_value(out_led, !led0, "led blink");
        limit_active <= 1'b0;
        $display("test limit done");
    endtask
    // Main sequence
    initial begin
        mismatches = 0;
        n_compared = 0;
        cycles = 0;
        reset = 1'b1;
        {limit_active, oc_fault, ot_fault, ov_fault} = 4'h0;
        {hold_off, cycle_remote, cycle_present} = 3'h0;
        vout_above_10v = 1'b1;
        prog_pin_setpt = 8'h5A;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h0;
        s_awaddr = 8'h00;
        s_araddr = 8'h00;
        s_wdata = 32'h0;
        s_wstrb = 4'hF;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        test_regs();
        test_setpt();
        test_onoff();
        test_ov_window();
        test_latch();
        test_limit();
        stop_test();
    end
endmodule
